// ### cdf_cfg.svh
// offsets, field positions, reset values and sizes of the decimating filter pair
//
// Contract
// RULE1 - comb stage decimates by any integer ratio from 2 to 32
// RULE2 - comb stage is fifth order with gain divided by two to shift plus five
// RULE3 - comb attenuation shift runs 0 to 20, one bit of right shift per step
// RULE4 - configuration keeps comb input rate within clock rate over input_rate_divisor
// RULE5 - comb output rate is its input rate over ratio and feeds the filter
// RULE6 - comb stage accepts a new input sample on every clock
// RULE7 - filter keeps 160 newest complex samples, I and Q 20 bits, separate memories
// RULE8 - coefficient memory holds 256 coefficients of 20 bits
// RULE9 - each clock computes one I tap and one Q tap with one coefficient
// RULE10 - each filter result has 24-bit I and 24-bit Q
// RULE11 - 8-bit register at 0xA0 holds filter ratio minus one, ratios 1 to 256
// RULE12 - phase at 0xA1 preloads the filter decimation counter instead of zero
// RULE13 - tap count minus one sits at 0xA2, at most 160 taps
// RULE14 - coefficient words at window 0x00 to 0x7F are 20-bit two's complement
// RULE15 - low coefficient addresses meet older samples, any tap count, no symmetry
// RULE16 - host loads the whole impulse response including both symmetric halves
// RULE17 - coefficients written in two 128-word pages, core sees 256 contiguous words
// RULE18 - sample memory is a 160-entry circular buffer of 20-bit I and Q
// RULE19 - sum starts at oldest sample times coefficient at offset, runs offset+taps-1
// RULE20 - changing the coefficient offset selects another stored filter at once
// RULE21 - filter output rate is comb output rate over filter ratio
// RULE22 - page bit 0 writes taps 0 to 127, page bit 1 writes taps 128 to 255
// RULE23 - alternate-input bit takes filter input from the partner comb stage
// RULE24 - decimation counter counts comb samples and starts a sum at its terminal value
// RULE25 - comb attenuation shift is applied before the integrators
`ifndef CDF_CFG_SVH
`define CDF_CFG_SVH

// register indices; byte address is four times the index
`define CDF_IDX_COEF_LAST 8'h7F
`define CDF_IDX_DEC 8'hA0
`define CDF_IDX_PHASE 8'hA1
`define CDF_IDX_TAPS 8'hA2
`define CDF_IDX_COEF_OFF 8'hA3
`define CDF_IDX_CTRL 8'hA4
`define CDF_IDX_COMB 8'hA5
`define CDF_IDX_STATUS 8'hA6
`define CDF_AXI_AW 10

// field positions
`define CDF_CTRL_PAGE 8
`define CDF_CTRL_ALT 9
`define CDF_COMB_SHIFT_LSB 8
`define CDF_STAT_BUSY 0
`define CDF_STAT_OVERRUN 1
`define CDF_STAT_CNT_LSB 8

// reset values and limits
`define CDF_RST_COMB_RATIO 6'h02
`define CDF_COMB_RATIO_MIN 6'h02
`define CDF_COMB_RATIO_MAX 6'h20
`define CDF_COMB_SHIFT_MAX 5'h14
`define CDF_COMB_GAIN_SHIFT 5
`define CDF_TAPS_M1_MAX 8'h9F
`define CDF_SAMPLE_LAST 8'h9F
`define CDF_SAMPLE_DEPTH 9'h0A0

// data path sizes
`define CDF_DW 20
`define CDF_OW 24
`define CDF_CW 45
`define CDF_AW 48
`define CDF_OUT_LSB 19

`define CDF_RESP_OKAY 2'h0
`define CDF_RESP_SLVERR 2'h2

`endif

// ### cdf_pkg.sv
// types shared by the comb stage and the programmable coefficient filter
`include "cdf_cfg.svh"
package cdf_pkg;

    // complex sample between stages
    typedef struct packed {
        logic signed [`CDF_DW-1:0] i;
        logic signed [`CDF_DW-1:0] q;
    } cdf_iq_t;

    // complex filter result
    typedef struct packed {
        logic signed [`CDF_OW-1:0] i;
        logic signed [`CDF_OW-1:0] q;
    } cdf_out_t;

    // whole register state of the block
    typedef struct packed {
        logic aw_held;
        logic w_held;
        logic [7:0] aw_idx;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] dec_m1;
        logic [7:0] phase;
        logic [7:0] taps_m1;
        logic [7:0] coef_off;
        logic page;
        logic alt_sel;
        logic [5:0] comb_ratio;
        logic [4:0] comb_shift;
        logic overrun;
        logic [5:0] comb_cnt;
        logic [4:0][`CDF_CW-1:0] integ_i;
        logic [4:0][`CDF_CW-1:0] integ_q;
        logic [4:0][`CDF_CW-1:0] dly_i;
        logic [4:0][`CDF_CW-1:0] dly_q;
        logic comb_valid;
        cdf_iq_t comb;
        logic [7:0] wr_ptr;
        logic [7:0] rcf_cnt;
        logic busy;
        logic [7:0] tap;
        logic [7:0] rd_ptr;
        logic [7:0] caddr;
        logic signed [`CDF_AW-1:0] acc_i;
        logic signed [`CDF_AW-1:0] acc_q;
        logic out_valid;
        cdf_out_t out;
    } cdf_state_t;

endpackage

// ### cdf_filter.sv
// fifth-order comb decimator feeding a paged-coefficient sum-of-products decimator
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "cdf_cfg.svh"
module cdf_filter
    import cdf_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus, write address and data
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [`CDF_AXI_AW-1:0] s_awaddr,
    input wire logic [2:0] s_awprot,
    input wire logic s_wvalid,
    output logic s_wready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    // register bus, write response
    output logic s_bvalid,
    input wire logic s_bready,
    output logic [1:0] s_bresp,
    // register bus, read
    input wire logic s_arvalid,
    output logic s_arready,
    input wire logic [`CDF_AXI_AW-1:0] s_araddr,
    input wire logic [2:0] s_arprot,
    output logic s_rvalid,
    input wire logic s_rready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    // samples into the comb stage
    input wire logic in_valid,
    input wire cdf_iq_t in_data,
    // partner channel comb output, used when the alternate bit is set
    input wire logic alt_valid,
    input wire cdf_iq_t alt_data,
    // own comb output, offered to the partner channel
    output logic comb_valid,
    output cdf_iq_t comb_data,
    // filter results toward the half-band stage
    output logic out_valid,
    output cdf_out_t out_data
);

    // whole block state
    cdf_state_t st;
    cdf_state_t next_st;

    // sample and coefficient memories
    logic [`CDF_DW-1:0] mem_i [0:159];
    logic [`CDF_DW-1:0] mem_q [0:159];
    logic [`CDF_DW-1:0] coef_mem [0:255];

    logic coef_we;
    logic [7:0] coef_wa;
    logic [`CDF_DW-1:0] coef_wd;

    // sample memory write port
    logic smp_we;
    cdf_iq_t smp_wd;

    // ==============================================================
    // register read mux
    // ==============================================================
    function automatic logic [32:0] rd_word(input logic [7:0] idx, input cdf_state_t s,
                                            input logic [`CDF_DW-1:0] cword);
        logic [31:0] v;
        logic ok;
        v = 32'h0000_0000;
        ok = 1'b1;
        if (idx <= `CDF_IDX_COEF_LAST) begin
            v = {{(32-`CDF_DW){cword[`CDF_DW-1]}}, cword}; // [RULE14]
        end else begin
            unique case (idx)
                `CDF_IDX_DEC: v[7:0] = s.dec_m1;
                `CDF_IDX_PHASE: v[7:0] = s.phase;
                `CDF_IDX_TAPS: v[7:0] = s.taps_m1;
                `CDF_IDX_COEF_OFF: v[7:0] = s.coef_off;
                `CDF_IDX_CTRL: begin
                    v[`CDF_CTRL_PAGE] = s.page;
                    v[`CDF_CTRL_ALT] = s.alt_sel;
                end
                `CDF_IDX_COMB: begin
                    v[5:0] = s.comb_ratio;
                    v[`CDF_COMB_SHIFT_LSB+:5] = s.comb_shift;
                end
                `CDF_IDX_STATUS: begin
                    v[`CDF_STAT_BUSY] = s.busy;
                    v[`CDF_STAT_OVERRUN] = s.overrun;
                    v[`CDF_STAT_CNT_LSB+:8] = s.rcf_cnt;
                end
                default: ok = 1'b0;
            endcase
        end
        return {ok, v};
    endfunction

    // ==============================================================
    // next state
    // ==============================================================
    always_comb begin
        logic [32:0] rw;
        logic [31:0] mask;
        logic [31:0] wv;
        logic [`CDF_CW-1:0] n_i;
        logic [`CDF_CW-1:0] n_q;
        logic [`CDF_CW-1:0] c_i;
        logic [`CDF_CW-1:0] c_q;
        logic [`CDF_CW-1:0] d_i;
        logic [`CDF_CW-1:0] d_q;
        logic sel_valid;
        cdf_iq_t sel_data;
        logic [8:0] old_ptr;
        logic signed [2*`CDF_DW-1:0] p_i;
        logic signed [2*`CDF_DW-1:0] p_q;
        logic signed [`CDF_AW-1:0] a_i;
        logic signed [`CDF_AW-1:0] a_q;
        logic [7:0] ar_idx;
        logic [`CDF_DW-1:0] ar_coef;
        logic [`CDF_DW-1:0] aw_coef;

        next_st = st;
        coef_we = 1'b0;
        coef_wa = 8'h00;
        coef_wd = '0;
        rw = '0;
        mask = 32'h0000_0000;
        wv = 32'h0000_0000;
        old_ptr = 9'h000;
        p_i = '0;
        p_q = '0;
        a_i = '0;
        a_q = '0;

        // comb and select temporaries
        n_i = '0;
        n_q = '0;
        c_i = '0;
        c_q = '0;
        d_i = '0;
        d_q = '0;
        sel_valid = 1'b0;
        sel_data = '0;

        // read address and coefficient look-ups
        ar_idx = s_araddr[`CDF_AXI_AW-1:2];
        ar_coef = coef_mem[{st.page, ar_idx[6:0]}];
        aw_coef = coef_mem[{st.page, st.aw_idx[6:0]}];

        // write address and data are taken in either order
        if (s_awvalid && s_awready) begin
            next_st.aw_held = 1'b1;
            next_st.aw_idx = s_awaddr[`CDF_AXI_AW-1:2];
        end
        if (s_wvalid && s_wready) begin
            next_st.w_held = 1'b1;
            next_st.wdata = s_wdata;
            next_st.wstrb = s_wstrb;
        end
        if (st.bvalid && s_bready) begin
            next_st.bvalid = 1'b0;
        end

        // apply a held write, merging by byte strobe
        if (st.aw_held && st.w_held && !st.bvalid) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            rw = rd_word(st.aw_idx, st, aw_coef);
            for (int b = 0; b < 4; b++) begin
                mask[b*8+:8] = {8{st.wstrb[b]}};
            end
            wv = (rw[31:0] & ~mask) | (st.wdata & mask);
            next_st.bresp = rw[32] ? `CDF_RESP_OKAY : `CDF_RESP_SLVERR;

            // coefficients go to the selected page
            if (st.aw_idx <= `CDF_IDX_COEF_LAST) begin
                coef_we = 1'b1;
                coef_wa = {st.page, st.aw_idx[6:0]}; // [RULE17] [RULE22]
                coef_wd = wv[`CDF_DW-1:0];
            end else begin
                unique case (st.aw_idx)
                    `CDF_IDX_DEC: begin
                        next_st.dec_m1 = wv[7:0]; // [RULE11]
                        next_st.rcf_cnt = st.phase; // [RULE12]
                    end
                    `CDF_IDX_PHASE: begin
                        next_st.phase = wv[7:0];
                        next_st.rcf_cnt = wv[7:0]; // [RULE12]
                    end
                    `CDF_IDX_TAPS: begin
                        next_st.taps_m1 = (wv[7:0] > `CDF_TAPS_M1_MAX)
                            ? `CDF_TAPS_M1_MAX : wv[7:0]; // [RULE13]
                    end
                    `CDF_IDX_COEF_OFF: next_st.coef_off = wv[7:0]; // [RULE20]
                    `CDF_IDX_CTRL: begin
                        next_st.page = wv[`CDF_CTRL_PAGE];
                        next_st.alt_sel = wv[`CDF_CTRL_ALT];
                    end
                    `CDF_IDX_COMB: begin
                        if (wv[5:0] >= `CDF_COMB_RATIO_MIN && wv[5:0] <= `CDF_COMB_RATIO_MAX) begin
                            next_st.comb_ratio = wv[5:0]; // [RULE1]
                            next_st.comb_cnt = 6'h00;
                        end
                        if (wv[`CDF_COMB_SHIFT_LSB+:5] <= `CDF_COMB_SHIFT_MAX) begin
                            next_st.comb_shift = wv[`CDF_COMB_SHIFT_LSB+:5]; // [RULE3]
                        end
                    end
                    `CDF_IDX_STATUS: begin
                        if (wv[`CDF_STAT_OVERRUN]) begin
                            next_st.overrun = 1'b0;
                        end
                    end
                    default: ;
                endcase
            end
        end

        // read channel, one register answer per address
        if (st.rvalid && s_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (s_arvalid && s_arready) begin
            rw = rd_word(ar_idx, st, ar_coef);
            next_st.rvalid = 1'b1;
            next_st.rdata = rw[32] ? rw[31:0] : 32'h0000_0000;
            next_st.rresp = rw[32] ? `CDF_RESP_OKAY : `CDF_RESP_SLVERR;
        end

        // comb stage: shift, five integrators, decimate, five combs
        next_st.comb_valid = 1'b0;
        if (in_valid) begin // [RULE6]
            n_i = {{(`CDF_CW-`CDF_DW){in_data.i[`CDF_DW-1]}}, in_data.i};
            n_q = {{(`CDF_CW-`CDF_DW){in_data.q[`CDF_DW-1]}}, in_data.q};
            n_i = `CDF_CW'($signed(n_i) >>> st.comb_shift); // [RULE3] [RULE25]
            n_q = `CDF_CW'($signed(n_q) >>> st.comb_shift);

            // integrators may wrap; the combs undo it
            for (int k = 0; k < 5; k++) begin
                n_i = st.integ_i[k] + n_i; // [RULE2]
                n_q = st.integ_q[k] + n_q;
                next_st.integ_i[k] = n_i;
                next_st.integ_q[k] = n_q;
            end

            // every ratio-th sample runs the combs
            if (st.comb_cnt >= st.comb_ratio - 6'h01) begin
                next_st.comb_cnt = 6'h00; // [RULE1] [RULE5]
                c_i = n_i;
                c_q = n_q;
                for (int k = 0; k < 5; k++) begin
                    d_i = c_i - st.dly_i[k]; // [RULE2]
                    d_q = c_q - st.dly_q[k];
                    next_st.dly_i[k] = c_i;
                    next_st.dly_q[k] = c_q;
                    c_i = d_i;
                    c_q = d_q;
                end

                // fixed divide by 32
                c_i = `CDF_CW'($signed(c_i) >>> `CDF_COMB_GAIN_SHIFT); // [RULE2]
                c_q = `CDF_CW'($signed(c_q) >>> `CDF_COMB_GAIN_SHIFT);
                next_st.comb_valid = 1'b1;
                next_st.comb.i = c_i[`CDF_DW-1:0];
                next_st.comb.q = c_q[`CDF_DW-1:0];
            end else begin
                next_st.comb_cnt = st.comb_cnt + 6'h01;
            end
        end

        // filter input select and circular sample write
        sel_valid = st.alt_sel ? alt_valid : st.comb_valid; // [RULE23] [RULE21]
        sel_data = st.alt_sel ? alt_data : st.comb;
        smp_we = sel_valid;
        smp_wd = sel_data;

        // multiply-accumulate, one tap of I and Q per clock
        next_st.out_valid = 1'b0;
        if (st.busy) begin
            p_i = $signed(mem_i[st.rd_ptr]) * $signed(coef_mem[st.caddr]); // [RULE9]
            p_q = $signed(mem_q[st.rd_ptr]) * $signed(coef_mem[st.caddr]);
            a_i = st.acc_i + `CDF_AW'(p_i);
            a_q = st.acc_q + `CDF_AW'(p_q);
            next_st.acc_i = a_i;
            next_st.acc_q = a_q;
            next_st.rd_ptr = (st.rd_ptr == `CDF_SAMPLE_LAST) ? 8'h00 : st.rd_ptr + 8'h01;
            next_st.caddr = st.caddr + 8'h01; // [RULE17] [RULE19]
            next_st.tap = st.tap + 8'h01;

            // last tap publishes the result
            if (st.tap == st.taps_m1) begin
                next_st.busy = 1'b0;
                next_st.out_valid = 1'b1;
                next_st.out.i = a_i[`CDF_OUT_LSB+:`CDF_OW]; // [RULE10]
                next_st.out.q = a_q[`CDF_OUT_LSB+:`CDF_OW];
            end
        end

        // decimation counter and start of a sum
        if (sel_valid) begin
            next_st.wr_ptr = (st.wr_ptr == `CDF_SAMPLE_LAST) ? 8'h00 : st.wr_ptr + 8'h01; // [RULE18]
            if (st.rcf_cnt == st.dec_m1) begin
                next_st.rcf_cnt = 8'h00; // [RULE24]
                // a start while busy is dropped
                if (st.busy) begin
                    next_st.overrun = 1'b1;
                end else begin
                    // oldest sample of the window
                    old_ptr = {1'b0, st.wr_ptr} + `CDF_SAMPLE_DEPTH - {1'b0, st.taps_m1};
                    if (old_ptr >= `CDF_SAMPLE_DEPTH) begin
                        old_ptr = old_ptr - `CDF_SAMPLE_DEPTH;
                    end
                    next_st.busy = 1'b1;
                    next_st.rd_ptr = old_ptr[7:0]; // [RULE15] [RULE19]
                    next_st.caddr = st.coef_off; // [RULE19] [RULE20]
                    next_st.tap = 8'h00;
                    next_st.acc_i = '0;
                    next_st.acc_q = '0;
                end
            end else begin
                next_st.rcf_cnt = st.rcf_cnt + 8'h01; // [RULE24]
            end
        end
    end

    // ==============================================================
    // state register
    // ==============================================================
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.comb_ratio <= `CDF_RST_COMB_RATIO;
        end else begin
            st <= next_st;
        end
    end

    // ==============================================================
    // memories, no reset
    // ==============================================================
    always_ff @(posedge aclk) begin
        if (coef_we) begin
            coef_mem[coef_wa] <= coef_wd; // [RULE8] [RULE14]
        end

        // newest sample at the write pointer
        if (smp_we) begin
            mem_i[st.wr_ptr] <= smp_wd.i; // [RULE7] [RULE18]
            mem_q[st.wr_ptr] <= smp_wd.q;
        end
    end

    // ==============================================================
    // outputs
    // ==============================================================
    assign s_awready = !st.aw_held && !st.bvalid;
    assign s_wready = !st.w_held && !st.bvalid;
    assign s_bvalid = st.bvalid;
    assign s_bresp = st.bresp;
    assign s_arready = !st.rvalid;
    assign s_rvalid = st.rvalid;
    assign s_rdata = st.rdata;
    assign s_rresp = st.rresp;

    // stream outputs
    assign comb_valid = st.comb_valid;
    assign comb_data = st.comb;
    assign out_valid = st.out_valid;
    assign out_data = st.out;

endmodule

// ### cdf_src.sv
// sample source for the upstream comb stage and the partner channel
`timescale 1ns/1ns
module cdf_src
    import cdf_pkg::*;
(
    // clock and control
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic go,
    input wire logic [3:0] gap,
    input wire logic [19:0] val,
    // sample outputs
    output logic in_valid = 1'b0,
    output cdf_iq_t in_data = '0,
    output logic alt_valid = 1'b0,
    output cdf_iq_t alt_data = '0
);
    logic [3:0] cnt = 4'h0;
    logic hit;
    assign hit = go && cnt == 4'h0;
    // one sample every gap cycles, data scrambled between samples
    always @(posedge aclk) begin
        cnt <= (!aresetn || cnt == 4'h0) ? gap - 4'h1 : cnt - 4'h1;
        in_valid <= aresetn && hit;
        alt_valid <= aresetn && hit;
        in_data <= !aresetn ? '0 : hit ? {val, -val} : ~in_data;
        alt_data <= !aresetn ? '0 : hit ? {-val, val} : ~alt_data;
    end
endmodule

// ### cdf_filter_chk.sv
// port assertions for the comb decimator and coefficient filter
`timescale 1ns/1ns
module cdf_filter_chk
    import cdf_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic s_awvalid,
    input wire logic s_awready,
    input wire logic s_wvalid,
    input wire logic s_wready,
    input wire logic s_bvalid,
    input wire logic s_bready,
    input wire logic s_arvalid,
    input wire logic s_arready,
    input wire logic s_rvalid,
    input wire logic s_rready,
    input wire logic [31:0] s_rdata,
    // samples
    input wire logic in_valid,
    input wire logic alt_valid,
    input wire logic comb_valid,
    input wire logic out_valid,
    input wire cdf_out_t out_data
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic [7:0] since_in;
    // cycles since the last own or partner comb sample, saturating
    always_ff @(posedge aclk) begin
        if (!aresetn || comb_valid || alt_valid) begin
            since_in <= 8'h00;
        end else if (since_in != 8'hFF) begin
            since_in <= since_in + 8'h01;
        end
    end
    // ====================
    // write steps, then the bus and stream assertions
    sequence s_write_taken;
        s_awvalid && s_awready && s_wvalid && s_wready;
    endsequence
    sequence s_write_answer;
        ##[1:2] s_bvalid;
    endsequence
    a_write_answer: assert property (s_write_taken |-> s_write_answer)
        else $error("write response missing");
    a_write_blocks: assert property (s_bvalid |-> !s_awready && !s_wready)
        else $error("write taken during response");
    a_bresp_holds: assert property (s_bvalid && !s_bready |=> s_bvalid)
        else $error("write response dropped");
    a_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid && !s_arready)
        else $error("read answer late");
    a_rdata_holds: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
        else $error("read data changed");
    a_comb_cause: assert property (comb_valid |-> $past(in_valid))
        else $error("comb output without input");
    a_comb_pulse: assert property (comb_valid |=> !comb_valid)
        else $error("comb outputs too close");
    a_out_cause: assert property (out_valid |-> since_in <= 8'hA0)
        else $error("filter output without recent input");
    a_out_holds: assert property (!out_valid |-> $stable(out_data))
        else $error("filter output changed without strobe");
endmodule
bind cdf_filter cdf_filter_chk i_chk (
    .aclk, .aresetn, .s_awvalid, .s_awready, .s_wvalid, .s_wready, .s_bvalid, .s_bready,
    .s_arvalid, .s_arready, .s_rvalid, .s_rready, .s_rdata, .in_valid, .alt_valid,
    .comb_valid, .out_valid, .out_data
);

// ### cdf_filter_tb.sv
// self-checking bench for the comb decimator and coefficient filter
`timescale 1ns/1ns
module cdf_filter_tb
    import cdf_pkg::*;
;
    logic aclk = 1'b0, aresetn = 1'b0, go = 1'b0;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
    logic [9:0] s_awaddr = '0, s_araddr = '0;
    logic [31:0] s_wdata = '0, s_rdata;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic in_valid, alt_valid, comb_valid, out_valid;
    logic [1:0] s_bresp, s_rresp;
    logic [19:0] last_comb;
    cdf_iq_t in_data, alt_data, comb_data;
    cdf_out_t out_data;
    int errors = 0, n_compared = 0, cyc = 0, n_comb = 0, n_out = 0;
    logic [7:0] offs [6] = '{8'h00, 8'h01, 8'h00, 8'h7F, 8'h00, 8'h00};
    logic [7:0] tapm [6] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00};
    logic [31:0] comb [6] = '{32'h2, 32'h2, 32'h2, 32'h2, 32'h302, 32'h2};
    logic [31:0] ctrl [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h200};
    logic [23:0] e_i [6] = '{24'h800, 24'h400, 24'hC00, 24'hC00, 24'h100, 24'hFFF800};
    logic [31:0] ratios [3] = '{32'h2, 32'h5, 32'h20};
    cdf_filter i_dut (
        .aclk, .aresetn, .s_awvalid, .s_awready, .s_awaddr, .s_awprot(3'h0), .s_wvalid,
        .s_wready, .s_wdata, .s_wstrb(4'hF), .s_bvalid, .s_bready, .s_bresp, .s_arvalid,
        .s_arready, .s_araddr, .s_arprot(3'h0), .s_rvalid, .s_rready, .s_rdata, .s_rresp,
        .in_valid, .in_data, .alt_valid, .alt_data, .comb_valid, .comb_data, .out_valid,
        .out_data
    );
    cdf_src i_src (
        .aclk, .aresetn, .go, .gap(4'h4), .val(20'h01000), .in_valid, .in_data, .alt_valid,
        .alt_data
    );
    // ====================
    // clock, tallies and hang guard
    always #2 aclk = ~aclk;
    always @(negedge aclk) begin
        n_comb += int'(comb_valid);
        n_out += int'(out_valid);
        if (comb_valid) last_comb = comb_data.i;
    end
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            results();
        end
    end
    // ====================
    // tasks
    task automatic results();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one bus access; readiness raised late so held answers are seen
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d,
            output logic [31:0] q, output logic [1:0] r);
        logic ta, tw, tr, done;
        int it;
        done = 1'b0;
        it = 0;
        @(posedge aclk);
        s_awvalid <= w;
        s_wvalid <= w;
        s_arvalid <= !w;
        s_awaddr <= {idx, 2'h0};
        s_araddr <= {idx, 2'h0};
        s_wdata <= d;
        while (!done) begin
            @(negedge aclk);
            ta = s_awvalid && s_awready;
            tw = s_wvalid && s_wready;
            tr = s_arvalid && s_arready;
            done = w ? s_bvalid && s_bready : s_rvalid && s_rready;
            q = s_rdata;
            r = w ? s_bresp : s_rresp;
            it++;
            @(posedge aclk);
            if (ta) s_awvalid <= 1'b0;
            if (tw) s_wvalid <= 1'b0;
            if (tr) s_arvalid <= 1'b0;
            if (done) begin
                s_bready <= 1'b0;
                s_rready <= 1'b0;
            end else if (it > 2) begin
                s_bready <= w;
                s_rready <= !w;
            end
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] q;
        logic [1:0] r;
        bus(1'b1, idx, d, q, r);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] q;
        logic [1:0] r;
        bus(1'b0, idx, 32'h0, q, r);
        check(q, exp);
    endtask
    // send n samples, then let the pipeline drain
    task automatic feed(input int n);
        go <= 1'b1;
        repeat (n) begin
            do @(negedge aclk); while (in_valid !== 1'b1);
        end
        @(posedge aclk);
        go <= 1'b0;
        repeat (200) @(posedge aclk);
    endtask
    // ====================
    // main sequence
    initial begin
        logic [31:0] q;
        logic [1:0] r;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            rd(8'hA0 + 8'(k), 32'h0);
        end
        rd(8'hA5, 32'h2);
        bus(1'b0, 8'hB0, 32'h0, q, r);
        check(q, 32'h0);
        check({30'h0, r}, 32'h2);
        bus(1'b1, 8'hB0, 32'h5, q, r);
        check({30'h0, r}, 32'h2);
        wr(8'hA2, 32'hFF);
        rd(8'hA2, 32'h9F);
        wr(8'h7F, 32'h80000);
        wr(8'hA4, 32'h100);
        wr(8'h7F, 32'h12345);
        rd(8'h7F, 32'h12345);
        wr(8'h00, 32'h20000);
        wr(8'hA4, 32'h0);
        rd(8'h7F, 32'hFFF80000);
        wr(8'h7F, 32'h40000);
        wr(8'h00, 32'h40000);
        wr(8'h01, 32'h20000);
        // offset, length, shift and input source against a steady input
        for (int k = 0; k < 6; k++) begin
            wr(8'hA3, {24'h0, offs[k]});
            wr(8'hA2, {24'h0, tapm[k]});
            wr(8'hA5, comb[k]);
            wr(8'hA4, ctrl[k]);
            feed(40);
            check({8'h0, out_data.i}, {8'h0, e_i[k]});
            check({8'h0, out_data.q}, {8'h0, -e_i[k]});
            check({12'h0, last_comb}, {12'h0, 20'h01000 >> comb[k][12:8]});
        end
        wr(8'hA4, 32'h0);
        wr(8'hA0, 32'h3);
        n_out = 0;
        feed(32);
        check(n_out, 4);
        wr(8'hA1, 32'h2);
        n_out = 0;
        feed(4);
        check(n_out, 1);
        wr(8'hA1, 32'h0);
        n_out = 0;
        feed(4);
        check(n_out, 0);
        rd(8'hA6, 32'h200);
        for (int k = 0; k < 3; k++) begin
            wr(8'hA5, ratios[k]);
            n_comb = 0;
            feed(3 * int'(ratios[k]));
            check(n_comb, 3);
        end
        wr(8'hA5, 32'h21);
        rd(8'hA5, 32'h20);
        results();
    end
endmodule
